// *** hdl/wdt_params.svh ***
// Notes on behaviour
// - mode 00 turns both timers off; 01 runs the countdown, interrupt optional
// - mode 10 is watchdog to interrupt, 11 watchdog to reset; no countdown
// - bit 5 picks interrupt style: 0 level while flags set, 1 pulse on set
// - source clock select: 00 4.096 kHz, 01 64 Hz, 10 1 Hz, 11 1/60 Hz
// - period is n ticks of the selected source clock, n from 01 to ff
// - watchdog counts down from n; at 1 it sets its flag, then int or reset
// - an expired watchdog stays expired until the value register is written
// - watchdog write of nonzero n clears flag, drops output, restarts from n
// - watchdog write of zero clears flag, drops output and halts the counter
// - watchdog flag ignores writes; cleared by a value load or a flag read
// - reset pulse is 244 us at 4.096 kHz, otherwise 15.625 ms
// - countdown at 1 sets its flag, reloads n and starts the next period
// - countdown with value zero stops; no periods or flags until nonzero
// - reading the value register returns the live count, not n
// - new n takes effect at once; later reloads use the stored n
// - countdown drives interrupt only with its enable set; style per bit 5
// - countdown flag sets every period and clears only by a host write
// - first period may be up to a tick short of n, never longer
// - flag register writes AND each flag but watchdog; 0 clears, 1 keeps, sets not lost
// - flags: bit 7 min/sec, 6 watchdog, 5 stamp, 4 alarm, 3 countdown
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH

// register offsets
`define WDT_ADDR_FLAGS     8'h01
`define WDT_ADDR_TCTL      8'h10
`define WDT_ADDR_TVAL      8'h11

// timer_control fields and reset value
`define WDT_MODE_MSB       7
`define WDT_MODE_LSB       6
`define WDT_PSEL_BIT       5
`define WDT_TF_MSB         1
`define WDT_TF_LSB         0
`define WDT_TCTL_RST       8'h03
`define WDT_TVAL_RST       8'h00
`define WDT_CNT_LAST       8'h01

// flag register bits
`define WDT_MSF_BIT        7
`define WDT_WDOG_EXPIRY_FLAG_BIT       6
`define WDT_SECOND_STAMP_FLAG_BIT       5
`define WDT_AF_BIT         4
`define WDT_COUNTDOWN_EXPIRY_FLAG_BIT       3
`define WDT_COUNTDOWN_INT_ENABLE_BIT      0
`define WDT_LOW_RST        3'h0

// mode and source clock codes
`define WDT_MODE_OFF       2'h0
`define WDT_MODE_CD        2'h1
`define WDT_MODE_WD_INT    2'h2
`define WDT_MODE_WD_RST    2'h3
`define WDT_TF_4K          2'h0
`define WDT_TF_64          2'h1
`define WDT_TF_1HZ         2'h2
`define WDT_TF_MIN         2'h3

// prescaler terminal counts on the 32.768 kHz tick
`define WDT_DIV_W          15
`define WDT_DIV_4K_MASK    15'h0007
`define WDT_DIV_64_MASK    15'h01ff
`define WDT_DIV_1HZ_MASK   15'h7fff
`define WDT_SEC_LAST       6'h3b

// times in ns, converted to cycles in the top module
`define WDT_CLK_PERIOD_NS  10
`define WDT_RST_SHORT_NS   244000
`define WDT_RST_LONG_NS    15625000
`define WDT_INT_PULSE_NS   1000

`endif

// *** hdl/wdt_pkg.sv ***
package wdt_pkg;

  typedef logic [1:0] wdt_mode_t;
  typedef logic [1:0] wdt_tf_t;
  typedef logic [7:0] wdt_byte_t;

  // reset output sequencer
  typedef enum logic [0:0] {
    WDT_RST_IDLE,
    WDT_RST_HOLD
  } wdt_rst_state_e;

endpackage

// *** hdl/wdt_tick_gen.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "wdt_params.svh"

module wdt_tick_gen
  import wdt_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // 32.768 kHz oscillator enable
  input  wire logic       osc_tick,
  // source ticks, indexed by source clock code
  output logic      [3:0] tick
);

  logic [`WDT_DIV_W-1:0] div_reg;
  logic [`WDT_DIV_W-1:0] div_next;
  logic [5:0]            sec_reg;
  logic [5:0]            sec_next;
  logic [3:0]            tick_reg;
  logic [3:0]            tick_next;
  logic                  t4k;
  logic                  t64;
  logic                  t1;

  // free-running prescaler, so the first period of a run may be short
  always_comb begin
    t4k       = osc_tick && ((div_reg & `WDT_DIV_4K_MASK) == `WDT_DIV_4K_MASK);
    t64       = osc_tick && ((div_reg & `WDT_DIV_64_MASK) == `WDT_DIV_64_MASK);
    t1        = osc_tick && (div_reg == `WDT_DIV_1HZ_MASK);
    div_next  = osc_tick ? div_reg + 1'b1 : div_reg;
    sec_next  = sec_reg;
    if (t1) begin
      sec_next = (sec_reg == `WDT_SEC_LAST) ? '0 : sec_reg + 1'b1;
    end
    tick_next = '0;
    tick_next[`WDT_TF_4K] = t4k;
    tick_next[`WDT_TF_64] = t64;
    tick_next[`WDT_TF_1HZ] = t1;
    tick_next[`WDT_TF_MIN] = t1 && (sec_reg == `WDT_SEC_LAST);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div_reg  <= '0;
      sec_reg  <= '0;
      tick_reg <= '0;
    end else begin
      div_reg  <= div_next;
      sec_reg  <= sec_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

endmodule

`default_nettype wire

// *** hdl/wdt_timer.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "wdt_params.svh"

module wdt_timer
  import wdt_pkg::*;
#(
  parameter int unsigned RST_SHORT_CYC = `WDT_RST_SHORT_NS /
                                         `WDT_CLK_PERIOD_NS,
  parameter int unsigned RST_LONG_CYC  = `WDT_RST_LONG_NS / `WDT_CLK_PERIOD_NS,
  parameter int unsigned INT_PULSE_CYC = `WDT_INT_PULSE_NS /
                                         `WDT_CLK_PERIOD_NS,
  parameter int unsigned RCW           = 21
) (
  // clock and reset
  input  wire logic       SYS_CLK,
  input  wire logic       RST,
  // 32.768 kHz oscillator enable, one cycle per oscillator period
  input  wire logic       OSC_TICK,
  // register port
  input  wire logic [7:0] REG_ADDR,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  input  wire logic [7:0] REG_WDATA,
  output logic      [7:0] REG_RDATA,
  // flag set events from the neighbouring functions
  input  wire logic       MSF_SET,
  input  wire logic       SECOND_STAMP_FLAG_SET,
  input  wire logic       AF_SET,
  // open-drain interrupt pin
  output logic            INT_O,
  output logic            INT_OE,
  // open-drain reset pin
  output logic            WDOG_RST_O,
  output logic            WDOG_RST_OE
);

  localparam logic [RCW-1:0] RST_SHORT = RCW'(RST_SHORT_CYC);
  localparam logic [RCW-1:0] RST_LONG  = RCW'(RST_LONG_CYC);
  localparam logic [RCW-1:0] INT_PULSE = RCW'(INT_PULSE_CYC);

  // register state
  logic [7:0]     tctl_reg;
  logic [7:0]     tctl_next;
  logic [2:0]     low_reg;
  logic [2:0]     low_next;
  logic           msf_reg;
  logic           msf_next;
  logic           wdog_expiry_flag_reg;
  logic           wdog_expiry_flag_next;
  logic           second_stamp_flag_reg;
  logic           second_stamp_flag_next;
  logic           af_reg;
  logic           af_next;
  logic           countdown_expiry_flag_reg;
  logic           countdown_expiry_flag_next;
  logic           load_reg;
  logic           load_next;
  wdt_byte_t      load_val_reg;
  wdt_byte_t      load_val_next;
  wdt_byte_t      reload_reg;
  wdt_byte_t      reload_next;
  wdt_byte_t      cnt_reg;
  wdt_byte_t      cnt_next;
  wdt_byte_t      rdata_reg;
  wdt_byte_t      rdata_next;

  // output state
  wdt_rst_state_e rst_state_reg;
  wdt_rst_state_e rst_state_next;
  logic [RCW-1:0] rst_cnt_reg;
  logic [RCW-1:0] rst_cnt_next;
  logic [RCW-1:0] int_cnt_reg;
  logic [RCW-1:0] int_cnt_next;
  logic           int_oe_reg;
  logic           int_oe_next;
  logic           rst_oe_reg;
  logic           rst_oe_next;

  // decoded control
  wdt_mode_t      mode;
  wdt_tf_t        tf;
  logic           psel;
  logic           countdown_int_enable;
  logic [3:0]     ticks;
  logic           tick_sel;
  logic           running;
  logic           expire;
  logic           wd_exp;
  logic           cd_exp;
  logic           wr_flags;
  logic           wr_tctl;
  logic           wr_tval;
  logic           rd_flags;

  // source clock ticks
  wdt_tick_gen u_tick_gen (
    .clk      (SYS_CLK),
    .rst      (RST),
    .osc_tick (OSC_TICK),
    .tick     (ticks)
  );

  // field decode and access strobes
  always_comb begin
    mode     = tctl_reg[`WDT_MODE_MSB:`WDT_MODE_LSB];
    psel     = tctl_reg[`WDT_PSEL_BIT];
    tf       = tctl_reg[`WDT_TF_MSB:`WDT_TF_LSB];
    countdown_int_enable    = low_reg[`WDT_COUNTDOWN_INT_ENABLE_BIT];
    tick_sel = ticks[tf];
    wr_flags = REG_WR && (REG_ADDR == `WDT_ADDR_FLAGS);
    wr_tctl  = REG_WR && (REG_ADDR == `WDT_ADDR_TCTL);
    wr_tval  = REG_WR && (REG_ADDR == `WDT_ADDR_TVAL);
    rd_flags = REG_RD && (REG_ADDR == `WDT_ADDR_FLAGS);
    // mode 00 stops both timers; a zero count is halted too
    running  = (mode != `WDT_MODE_OFF) && (cnt_reg != '0);
    // a pending load wins over a tick in the same cycle
    expire   = tick_sel && running && !load_reg && (cnt_reg == `WDT_CNT_LAST);
    wd_exp   = expire && mode[1];
    cd_exp   = expire && (mode == `WDT_MODE_CD);
  end

  // registers, counter and flags
  always_comb begin
    tctl_next     = tctl_reg;
    low_next      = low_reg;
    load_next     = 1'b0;
    load_val_next = load_val_reg;
    reload_next   = reload_reg;
    cnt_next      = cnt_reg;
    rdata_next    = rdata_reg;
    if (wr_tctl) begin
      // unused bits 4:2 are not stored and read back as zero
      tctl_next = REG_WDATA & `WDT_TCTL_RST;
      tctl_next[`WDT_MODE_MSB:`WDT_MODE_LSB] =
        REG_WDATA[`WDT_MODE_MSB:`WDT_MODE_LSB];
      tctl_next[`WDT_PSEL_BIT] = REG_WDATA[`WDT_PSEL_BIT];
    end
    if (wr_flags) begin
      low_next = REG_WDATA[2:0];
    end
    // a value write is captured, then applied as one load the next cycle
    if (wr_tval) begin
      load_next     = 1'b1;
      load_val_next = REG_WDATA;
    end
    if (load_reg) begin
      // takes effect at once, even mid-period; reload uses the new n
      cnt_next    = load_val_reg;
      reload_next = load_val_reg;
    end else if (tick_sel && running) begin
      if (cnt_reg == `WDT_CNT_LAST) begin
        // watchdog parks at zero, the countdown starts over
        cnt_next = (mode == `WDT_MODE_CD) ? reload_reg : '0;
      end else begin
        cnt_next = cnt_reg - 8'h01;
      end
    end
    // flags: a set in the same cycle as a clear always survives
    msf_next  = (msf_reg & ~(wr_flags & ~REG_WDATA[`WDT_MSF_BIT]))
                | MSF_SET;
    second_stamp_flag_next = (second_stamp_flag_reg & ~(wr_flags & ~REG_WDATA[`WDT_SECOND_STAMP_FLAG_BIT]))
                | SECOND_STAMP_FLAG_SET;
    af_next   = (af_reg & ~(wr_flags & ~REG_WDATA[`WDT_AF_BIT]))
                | AF_SET;
    countdown_expiry_flag_next = (countdown_expiry_flag_reg & ~(wr_flags & ~REG_WDATA[`WDT_COUNTDOWN_EXPIRY_FLAG_BIT]))
                | cd_exp;
    // watchdog flag ignores the written bit entirely
    wdog_expiry_flag_next = (wdog_expiry_flag_reg & ~load_reg & ~rd_flags) | wd_exp;
    // read data is sampled from the current state
    if (REG_RD) begin
      case (REG_ADDR)
        `WDT_ADDR_FLAGS: begin
          rdata_next = {msf_reg, wdog_expiry_flag_reg, second_stamp_flag_reg, af_reg, countdown_expiry_flag_reg,
                        low_reg};
        end
        `WDT_ADDR_TCTL: begin
          rdata_next = tctl_reg;
        end
        `WDT_ADDR_TVAL: begin
          rdata_next = cnt_reg;
        end
        default: begin
          rdata_next = '0;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      tctl_reg     <= `WDT_TCTL_RST;
      low_reg      <= `WDT_LOW_RST;
      msf_reg      <= 1'b0;
      wdog_expiry_flag_reg     <= 1'b0;
      second_stamp_flag_reg     <= 1'b0;
      af_reg       <= 1'b0;
      countdown_expiry_flag_reg     <= 1'b0;
      load_reg     <= 1'b0;
      load_val_reg <= `WDT_TVAL_RST;
      reload_reg   <= `WDT_TVAL_RST;
      cnt_reg      <= `WDT_TVAL_RST;
      rdata_reg    <= '0;
    end else begin
      tctl_reg     <= tctl_next;
      low_reg      <= low_next;
      msf_reg      <= msf_next;
      wdog_expiry_flag_reg     <= wdog_expiry_flag_next;
      second_stamp_flag_reg     <= second_stamp_flag_next;
      af_reg       <= af_next;
      countdown_expiry_flag_reg     <= countdown_expiry_flag_next;
      load_reg     <= load_next;
      load_val_reg <= load_val_next;
      reload_reg   <= reload_next;
      cnt_reg      <= cnt_next;
      rdata_reg    <= rdata_next;
    end
  end

  // interrupt and reset pin drivers
  always_comb begin
    rst_state_next = rst_state_reg;
    rst_cnt_next   = rst_cnt_reg;
    int_cnt_next   = int_cnt_reg;
    // pulse style: restart the pulse on a fresh min/sec flag set or an enabled countdown expiry
    if ((MSF_SET && !msf_reg) || (cd_exp && countdown_int_enable)) begin
      int_cnt_next = INT_PULSE;
    end else if (int_cnt_reg != '0) begin
      int_cnt_next = int_cnt_reg - 1'b1;
    end
    // level style follows the flags; watchdog interrupt is always a level
    if (psel) begin
      int_oe_next = (int_cnt_reg != '0);
    end else begin
      int_oe_next = msf_reg
                    | (countdown_expiry_flag_reg & countdown_int_enable & (mode == `WDT_MODE_CD));
    end
    if (wdog_expiry_flag_reg && (mode == `WDT_MODE_WD_INT)) begin
      int_oe_next = 1'b1;
    end
    case (rst_state_reg)
      WDT_RST_IDLE: begin
        if (wd_exp && (mode == `WDT_MODE_WD_RST)) begin
          rst_state_next = WDT_RST_HOLD;
          // width depends on the source clock in use
          rst_cnt_next = (tf == `WDT_TF_4K) ? RST_SHORT : RST_LONG;
        end
      end
      WDT_RST_HOLD: begin
        // a load ends the pulse early so the host can release itself
        if (load_reg || (rst_cnt_reg <= RCW'(1))) begin
          rst_state_next = WDT_RST_IDLE;
          rst_cnt_next   = '0;
        end else begin
          rst_cnt_next = rst_cnt_reg - 1'b1;
        end
      end
      default: begin
        rst_state_next = WDT_RST_IDLE;
        rst_cnt_next   = '0;
      end
    endcase
    rst_oe_next = (rst_state_next == WDT_RST_HOLD);
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      rst_state_reg <= WDT_RST_IDLE;
      rst_cnt_reg   <= '0;
      int_cnt_reg   <= '0;
      int_oe_reg    <= 1'b0;
      rst_oe_reg    <= 1'b0;
    end else begin
      rst_state_reg <= rst_state_next;
      rst_cnt_reg   <= rst_cnt_next;
      int_cnt_reg   <= int_cnt_next;
      int_oe_reg    <= int_oe_next;
      rst_oe_reg    <= rst_oe_next;
    end
  end

  // open-drain pins only ever pull low
  assign INT_O       = 1'b0;
  assign WDOG_RST_O  = 1'b0;
  assign INT_OE      = int_oe_reg;
  assign WDOG_RST_OE = rst_oe_reg;
  assign REG_RDATA   = rdata_reg;

endmodule

`default_nettype wire

// *** dv/wdt_timer_sva.sv ***
`timescale 1ns/1ns
`default_nettype none
module wdt_timer_sva #(
  parameter int unsigned RST_SHORT_CYC = 8,
  parameter int unsigned RST_LONG_CYC  = 20,
  parameter int unsigned INT_PULSE_CYC = 4
) (
  // clock and reset
  input wire logic       SYS_CLK,
  input wire logic       RST,
  // register port
  input wire logic [7:0] REG_ADDR,
  input wire logic       REG_WR,
  input wire logic       REG_RD,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  // pin enables
  input wire logic       INT_OE,
  input wire logic       WDOG_RST_OE
);
  logic [7:0]  ctl_reg;
  logic [7:0]  ctl_next;
  logic [31:0] rc_reg;
  logic [31:0] rc_next;
  logic [31:0] ic_reg;
  logic [31:0] ic_next;
  logic [2:0]  ld_reg;
  logic [2:0]  ld_next;
  logic [31:0] rst_exp;
  logic        tv_wr;

  // control shadow, pulse widths and recent value loads (which end pulses)
  always_comb begin
    tv_wr = REG_WR && REG_ADDR == 8'h11;
    ctl_next = ctl_reg;
    if (REG_WR && REG_ADDR == 8'h10) ctl_next = REG_WDATA & 8'he3;
    rc_next = WDOG_RST_OE ? rc_reg + 32'h1 : 32'h0;
    ic_next = INT_OE ? ic_reg + 32'h1 : 32'h0;
    ld_next = {ld_reg[1:0], tv_wr};
    rst_exp = (ctl_reg[1:0] == 2'h0) ? RST_SHORT_CYC : RST_LONG_CYC;
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ctl_reg <= 8'h03;
      rc_reg <= 32'h0;
      ic_reg <= 32'h0;
      ld_reg <= 3'h0;
    end else begin
      ctl_reg <= ctl_next;
      rc_reg <= rc_next;
      ic_reg <= ic_next;
      ld_reg <= ld_next;
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  sequence s_ctl_wr;
    REG_WR && REG_ADDR == 8'h10;
  endsequence
  sequence s_ctl_rd;
    REG_RD && REG_ADDR == 8'h10;
  endsequence

  chk_ctl_readback: assert property (s_ctl_wr ##2 s_ctl_rd |=>
    REG_RDATA == ($past(REG_WDATA, 3) & 8'he3))
    else $error("control readback differs");
  chk_reset_quiet: assert property (disable iff (1'b0) RST |=>
    REG_RDATA == 8'h00 && !INT_OE && !WDOG_RST_OE)
    else $error("outputs not quiet in reset");
  chk_unmapped_read: assert property (REG_RD &&
    !(REG_ADDR inside {8'h01, 8'h10, 8'h11}) |=> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  chk_rst_width: assert property ($fell(WDOG_RST_OE) |->
    rc_reg == rst_exp || ld_reg != 3'h0)
    else $error("reset pulse width off");
  chk_int_width: assert property ($fell(INT_OE) && ctl_reg[5] &&
    ctl_reg[7:6] != 2'h2 |-> ic_reg == INT_PULSE_CYC)
    else $error("interrupt pulse width off");
  chk_rst_mode: assert property ($rose(WDOG_RST_OE) |->
    ctl_reg[7:6] == 2'h3)
    else $error("reset outside reset mode");
  chk_int_load_clr: assert property (tv_wr && ctl_reg[7:6] == 2'h2 &&
    REG_WDATA > 8'h01 |-> ##3 !INT_OE)
    else $error("load left interrupt active");
  chk_rst_load_clr: assert property (tv_wr && WDOG_RST_OE |->
    ##3 !WDOG_RST_OE)
    else $error("load left reset active");
endmodule
`default_nettype wire

// *** dv/wdt_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module wdt_host_model (
  // clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  // open-drain pins of the device
  input  wire logic        INT_O,
  input  wire logic        INT_OE,
  input  wire logic        WDOG_RST_O,
  input  wire logic        WDOG_RST_OE,
  // pin levels and width of the last reset pulse
  output logic             int_n,
  output logic             rst_n,
  output logic      [31:0] rst_width
);
  logic [31:0] run;

  // pull-ups hold both lines high unless the device sinks them
  assign int_n = INT_OE ? INT_O : 1'b1;
  assign rst_n = WDOG_RST_OE ? WDOG_RST_O : 1'b1;

  // host measures each low pulse on its reset line
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      run <= 32'h0;
      rst_width <= 32'h0;
    end else if (!rst_n) begin
      run <= run + 32'h1;
    end else if (run != 32'h0) begin
      rst_width <= run;
      run <= 32'h0;
    end
  end
endmodule
`default_nettype wire

// *** dv/wdt_timer_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module wdt_timer_tb;
  localparam int LIMIT = 20000;
  logic        SYS_CLK = 1'b0;
  logic        RST = 1'b1;
  logic        OSC_TICK = 1'b0;
  logic [7:0]  REG_ADDR = 8'h00;
  logic        REG_WR = 1'b0;
  logic        REG_RD = 1'b0;
  logic [7:0]  REG_WDATA = 8'h00;
  logic [2:0]  sets = 3'h0;
  logic [7:0]  REG_RDATA;
  logic        INT_O;
  logic        INT_OE;
  logic        WDOG_RST_O;
  logic        WDOG_RST_OE;
  logic        int_n;
  logic        rst_n;
  logic [31:0] rst_width;
  logic [7:0]  r1;
  logic [7:0]  r2;
  int          n_errors = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          a;
  int          b;

  // oscillator ticks every other cycle: one 4.096 kHz tick per 16 cycles
  always #5 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK) OSC_TICK <= ~OSC_TICK;

  wdt_timer #(.RST_SHORT_CYC(8), .RST_LONG_CYC(20), .INT_PULSE_CYC(4)) DUT (
    .SYS_CLK(SYS_CLK), .RST(RST), .OSC_TICK(OSC_TICK),
    .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .MSF_SET(sets[2]),
    .SECOND_STAMP_FLAG_SET(sets[1]), .AF_SET(sets[0]), .INT_O(INT_O), .INT_OE(INT_OE),
    .WDOG_RST_O(WDOG_RST_O), .WDOG_RST_OE(WDOG_RST_OE));
  wdt_host_model u_host (
    .SYS_CLK(SYS_CLK), .RST(RST), .INT_O(INT_O), .INT_OE(INT_OE),
    .WDOG_RST_O(WDOG_RST_O), .WDOG_RST_OE(WDOG_RST_OE),
    .int_n(int_n), .rst_n(rst_n), .rst_width(rst_width));

  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // a hang costs one mismatch and ends the run
  always @(posedge SYS_CLK) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_errors++;
      conclude();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge SYS_CLK);
    #1;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge SYS_CLK);
    REG_ADDR <= ad;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge SYS_CLK);
    REG_WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [7:0] d);
    @(posedge SYS_CLK);
    REG_ADDR <= ad;
    REG_RD <= 1'b1;
    @(posedge SYS_CLK);
    REG_RD <= 1'b0;
    #1 d = REG_RDATA;
  endtask
  task automatic rdck(input logic [7:0] ad, input logic [7:0] exp);
    logic [7:0] d;
    rd(ad, d);
    chk(d, exp);
  endtask
  // live count cannot be frozen, so accept only two agreeing reads
  task automatic rd2(output logic [7:0] d);
    logic [7:0] e;
    do begin
      rd(8'h11, d);
      rd(8'h11, e);
    end while (d !== e);
  endtask
  function automatic logic pin(input int s);
    return (s == 0) ? !int_n : !rst_n;
  endfunction
  // cycles until a pin reaches the given level, bounded
  task automatic wt(input int s, input logic v, output int n);
    n = 0;
    do begin
      idle(1);
      n++;
    end while (pin(s) !== v && n < 2000);
  endtask

  task automatic t_reset();
    rdck(8'h10, 8'h03);
    rdck(8'h11, 8'h00);
    rdck(8'h01, 8'h00);
    rdck(8'h20, 8'h00);
    wr(8'h10, 8'h1c);
    rdck(8'h10, 8'h00);
    wr(8'h11, 8'h02);
    idle(100);
    rdck(8'h11, 8'h02);
    rdck(8'h01, 8'h00);
  endtask
  task automatic t_flags();
    @(posedge SYS_CLK) sets <= 3'h7;
    @(posedge SYS_CLK) sets <= 3'h0;
    rdck(8'h01, 8'hb0);
    chk(pin(0), 1'b1);
    wr(8'h01, 8'h38);
    rdck(8'h01, 8'h30);
    chk(pin(0), 1'b0);
    wr(8'h01, 8'h00);
    // a set landing in the same cycle as its clear must survive
    @(posedge SYS_CLK);
    REG_ADDR <= 8'h01;
    REG_WDATA <= 8'h00;
    REG_WR <= 1'b1;
    sets <= 3'h7;
    @(posedge SYS_CLK);
    REG_WR <= 1'b0;
    sets <= 3'h0;
    rdck(8'h01, 8'hb0);
    wr(8'h01, 8'h00);
  endtask
  task automatic t_countdown();
    wr(8'h01, 8'h01);
    wr(8'h10, 8'h40);
    wr(8'h11, 8'h03);
    wt(0, 1'b1, a);
    chk(pin(0), 1'b1);
    rdck(8'h01, 8'h09);
    rdck(8'h01, 8'h09);
    wr(8'h01, 8'hb1);
    rdck(8'h01, 8'h01);
    chk(pin(0), 1'b0);
    wr(8'h10, 8'h60);
    wt(0, 1'b1, a);
    wt(0, 1'b0, a);
    chk(a == 4, 1'b1);
    wt(0, 1'b1, b);
    chk(a + b == 48, 1'b1);
    wr(8'h01, 8'h00);
    wr(8'h10, 8'h40);
    idle(60);
    chk(pin(0), 1'b0);
    rdck(8'h01, 8'h08);
    wr(8'h11, 8'h00);
    wr(8'h01, 8'h00);
    idle(100);
    rdck(8'h01, 8'h00);
    rdck(8'h11, 8'h00);
  endtask
  task automatic t_live();
    wr(8'h11, 8'hc8);
    idle(100);
    rd2(r1);
    idle(160);
    rd2(r2);
    chk(r1 < 8'hc8, 1'b1);
    chk((r1 - r2) inside {[8'd9:8'd11]}, 1'b1);
    wr(8'h01, 8'h01);
    wr(8'h11, 8'h03);
    wt(0, 1'b1, a);
    chk(a < 60, 1'b1);
    wr(8'h11, 8'h00);
    wr(8'h01, 8'h00);
  endtask
  task automatic t_wd_int();
    wr(8'h10, 8'h80);
    wr(8'h11, 8'h02);
    wt(0, 1'b1, a);
    chk(a < 40, 1'b1);
    rdck(8'h11, 8'h00);
    idle(50);
    chk(pin(0), 1'b1);
    wr(8'h01, 8'h00);
    idle(3);
    chk(pin(0), 1'b1);
    rdck(8'h01, 8'h40);
    rdck(8'h01, 8'h00);
    idle(2);
    chk(pin(0), 1'b0);
    wr(8'h01, 8'h40);
    rdck(8'h01, 8'h00);
    wr(8'h11, 8'h02);
    wt(0, 1'b1, a);
    chk(pin(0), 1'b1);
    wr(8'h11, 8'h05);
    idle(3);
    chk(pin(0), 1'b0);
    wt(0, 1'b1, a);
    chk(a > 60 && a < 90, 1'b1);
    wr(8'h11, 8'h00);
    idle(120);
    chk(pin(0), 1'b0);
  endtask
  task automatic t_wd_rst();
    wr(8'h10, 8'hc0);
    wr(8'h11, 8'h01);
    wt(1, 1'b1, a);
    wt(1, 1'b0, a);
    idle(1);
    chk(rst_width[7:0], 8'h08);
    wr(8'h10, 8'hc1);
    wr(8'h11, 8'h01);
    wt(1, 1'b1, a);
    wt(1, 1'b0, a);
    idle(1);
    chk(rst_width[7:0], 8'h14);
    wr(8'h11, 8'h01);
    wt(1, 1'b1, a);
    chk(pin(1), 1'b1);
    wr(8'h11, 8'h00);
    idle(3);
    chk(pin(1), 1'b0);
    wr(8'h10, 8'h00);
  endtask

  initial begin
    repeat (3) @(posedge SYS_CLK);
    RST <= 1'b0;
    t_reset();
    t_flags();
    t_countdown();
    t_live();
    t_wd_int();
    t_wd_rst();
    conclude();
  end
endmodule

bind wdt_timer wdt_timer_sva #(
  .RST_SHORT_CYC(RST_SHORT_CYC),
  .RST_LONG_CYC(RST_LONG_CYC),
  .INT_PULSE_CYC(INT_PULSE_CYC)
) u_sva (
  .SYS_CLK(SYS_CLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
  .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
  .INT_OE(INT_OE), .WDOG_RST_OE(WDOG_RST_OE));
`default_nettype wire
